//--- core/pp_pkg.sv
// Purpose: constants and types shared by the power path selector files
// Assumes: comparator and supervisor flags arrive synchronous to core_clk
// Notes: register offsets are byte addresses on a 32-bit apb word map
//
// Behaviour
// - with path selection on, adapter first, usb second, battery third
// - path enable cleared: both input switches off, battery only
// - on external power, battery switch on for supplement need or while charging
// - losing the selected supply hands the bus to the next source
// - input connected above battery; supplement need when bus below battery
// - forced battery mode never reconnects inputs, even with battery removed
// - power path state readable in the path status register
// - usb limit decode: 00 gives 100 ma, 01 500 ma, 1x 2.75 a
// - programmed limit applies to usb only; adapter keeps fixed limit
// - input over-voltage sets a fault status bit
// - input over-voltage leaves input switch states untouched
// - thermal shutdown: input switches off, battery switch on
// - bus under output short threshold: inputs off, input pull-ups on
// - battery short without thermal shutdown: battery switch off, bus-battery pull-up on
// - boot hold ignores low-limit, enable, suspend; charger on, 100 ma
// - after boot hold the host control settings take effect
// - pack id source on unless asleep, level from select bits
// - deglitched pack id high declares battery removed, discharge on
// - overload: reduce charge first, supplement only at zero charge
// - charge starts with input present, both enables high, below recharge
// - safety timer starts at each charge cycle start
// - below 3 v charge current limited to 10 percent
// - charge runs precondition, constant current, constant voltage
// - above 125 c thermal loop overrides and reduces charge current
// - after termination, enable toggle or input re-insertion restarts charge; code only returns to idle, a new cycle still needs below recharge
// - termination disabled during thermal, overload loop or supplement
package pp_pkg;
    localparam logic [7:0] CFG_OFF  = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] CTL_OFF  = 8'h08;
    // charge config field positions
    localparam int CFG_PATH_EN  = 0;
    localparam int CFG_RUN_EN   = 1;
    localparam int CFG_LOW_SEL  = 2;
    localparam int CFG_RANGE    = 3;
    localparam int CFG_SUSPEND  = 4;
    localparam int CFG_ID_LSB   = 5;
    localparam int CFG_ID_W     = 2;
    localparam int CFG_W        = 7;
    localparam logic [CFG_W-1:0] CFG_RST = 7'h03;
    localparam int CTL_SLEEP    = 0;
    localparam int CTL_TMR_EXP  = 1;
    localparam logic [1:0] CTL_RST = 2'h0;
    // usb limit codes
    typedef enum logic [1:0] {
        LIM_100MA = 2'h0,
        LIM_500MA = 2'h1,
        LIM_2A75  = 2'h2
    } usb_lim_e;
    // source codes in the status register
    localparam logic [1:0] SRC_BATT = 2'h0;
    localparam logic [1:0] SRC_AC   = 2'h1;
    localparam logic [1:0] SRC_USB  = 2'h2;
    localparam int BOOT_CYCLES      = 1000;
    localparam int DEGLITCH_CYCLES  = 8;
    typedef enum logic [4:0] {
        CHG_IDLE = 5'h01,
        CHG_PRE  = 5'h02,
        CHG_CC   = 5'h04,
        CHG_CV   = 5'h08,
        CHG_DONE = 5'h10
    } chg_state_e;
endpackage

//--- core/pp_flags_if.sv
// Purpose: carries pack id raw flag and its deglitched result
// Assumes: single clock domain
// Notes: used between top and the deglitch filter
`timescale 1ns/1ps
`default_nettype none
interface pp_flags_if;
    logic raw;
    logic clean;
    modport filt (input raw, output clean);
    modport top  (output raw, input clean);
endinterface
`default_nettype wire

//--- core/pp_deglitch.sv
// Purpose: holds a flag until it has been steady for a set count
// Assumes: input synchronous to core_clk
// Notes: both edges deglitched, so a noisy pin cannot chatter the output
`timescale 1ns/1ps
`default_nettype none
module pp_deglitch
    import pp_pkg::*;
#(
    parameter int CYCLES = DEGLITCH_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    pp_flags_if.filt  f
);
    logic [15:0] cnt_r;
    logic        clean_r;

    // count while raw differs from output, flip when count reached
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r   <= 16'h0000;
            clean_r <= 1'b0;
        end else if (f.raw == clean_r) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r >= 16'(CYCLES - 1)) begin
            cnt_r   <= 16'h0000;
            clean_r <= f.raw;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
    assign f.clean = clean_r;
endmodule
`default_nettype wire

//--- core/power_path_selector.sv
// Purpose: power path source selection, usb limit and charge sequencing
// Assumes: analogue comparators deliver flags synchronous to core_clk
// Notes: registers reached over apb; switch outputs are combinational
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module power_path_selector
    import pp_pkg::*;
#(
    parameter int BOOT_HOLD = BOOT_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // comparator flags
    input  wire logic        ac_above_batt,
    input  wire logic        usb_above_batt,
    input  wire logic        ac_overvolt,
    input  wire logic        usb_overvolt,
    input  wire logic        bus_below_batt,
    input  wire logic        bus_below_short,
    input  wire logic        batt_short,
    input  wire logic        thermal_shutdown,
    input  wire logic        pack_id_high,
    input  wire logic        charge_at_zero,
    input  wire logic        overload_active,
    input  wire logic        thermal_loop_hot,
    input  wire logic        batt_below_recharge,
    input  wire logic        batt_below_3v,
    input  wire logic        batt_at_reg_volt,
    input  wire logic        charge_below_term,
    // switch and analogue controls
    output logic             ac_switch_on,
    output logic             usb_switch_on,
    output logic             batt_switch_on,
    output logic             input_pullups_on,
    output logic             batt_pullup_on,
    output logic             discharge_on,
    output logic             pack_id_src_on,
    output logic [1:0]       pack_id_current_select,
    output usb_lim_e         usb_limit,
    output logic             charge_enabled,
    output logic             charge_reduce,
    output logic             precharge_tenth,
    output logic             voltage_loop_on,
    output logic             safety_timer_start,
    output logic             term_enable
);
    logic [CFG_W-1:0] charge_config_register;
    logic [1:0]       ctl_r;
    logic [31:0]      rdata_r;
    logic [31:0]      boot_cnt_r;
    logic             boot_r;
    chg_state_e       chg_r;
    chg_state_e       chg_nxt;
    logic             run_en_d_r;
    logic             ext_d_r;
    logic             restart_r;
    logic             ovp_ac_r;
    logic             ovp_usb_r;
    logic             pack_gone;
    logic             eff_path_en;
    logic             eff_run_en;
    logic             eff_low;
    logic             eff_suspend;
    logic             ext_present;
    logic             supplement;
    logic             normal_ac;
    logic             normal_usb;
    logic [1:0]       src;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic             charging;
    logic [7:0]       power_path_status_register;

    pp_flags_if id_flag ();
    assign id_flag.raw = pack_id_high;

    // pack removal deglitch
    pp_deglitch #(
        .CYCLES (DEGLITCH_CYCLES)
    ) u_id_filt (
        .core_clk (core_clk),
        .nrst     (nrst),
        .f        (id_flag)
    );
    assign pack_gone    = id_flag.clean;
    assign discharge_on = pack_gone;

    // apb decode; single wait-free access phase
    assign pready  = 1'b1;
    assign addr_ok = (paddr == CFG_OFF) || (paddr == STAT_OFF) || (paddr == CTL_OFF);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign prdata  = rdata_r;

    // host writable registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            charge_config_register <= CFG_RST;
            ctl_r                  <= CTL_RST;
        end else if (wr_en) begin
            if (paddr == CFG_OFF) begin
                charge_config_register <= pwdata[CFG_W-1:0];
            end
            if (paddr == CTL_OFF) begin
                ctl_r <= pwdata[1:0];
            end
        end
    end

    // read data latched in setup cycle so it stands through access
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                CFG_OFF:  rdata_r <= {25'h0, charge_config_register};
                STAT_OFF: rdata_r <= {24'h0, power_path_status_register};
                CTL_OFF:  rdata_r <= {30'h0, ctl_r};
                default:  rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // boot hold counter; length is a parameter for short simulations
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            boot_cnt_r <= 32'h0000_0000;
            boot_r     <= 1'b1;
        end else if (boot_r) begin
            if (boot_cnt_r >= 32'(BOOT_HOLD - 1)) begin
                boot_r <= 1'b0;
            end else begin
                boot_cnt_r <= boot_cnt_r + 32'h0000_0001;
            end
        end
    end

    // boot defaults override host bits until hold ends
    assign eff_path_en = boot_r ? 1'b1 : charge_config_register[CFG_PATH_EN];
    assign eff_low     = boot_r ? 1'b0 : charge_config_register[CFG_LOW_SEL];
    assign eff_suspend = boot_r ? 1'b0 : charge_config_register[CFG_SUSPEND];
    assign eff_run_en  = boot_r ? 1'b1 : charge_config_register[CFG_RUN_EN];

    // usb limit decode; adapter limit is fixed in the analogue loop
    always_comb begin
        if (boot_r) begin
            usb_limit = LIM_100MA;
        end else if (charge_config_register[CFG_RANGE]) begin
            usb_limit = LIM_2A75;
        end else if (eff_low) begin
            usb_limit = LIM_500MA;
        end else begin
            usb_limit = LIM_100MA;
        end
    end

    // source selection; inputs detected above battery
    assign ext_present = ac_above_batt || usb_above_batt;
    assign supplement  = bus_below_batt && charge_at_zero;
    assign normal_ac   = eff_path_en && ac_above_batt;
    assign normal_usb  = eff_path_en && usb_above_batt && !ac_above_batt;
    // over-voltage deliberately not a term here, switches stay as they are
    always_comb begin
        ac_switch_on   = normal_ac && !thermal_shutdown && !bus_below_short;
        usb_switch_on  = normal_usb && !thermal_shutdown && !bus_below_short;
        if (thermal_shutdown) begin
            batt_switch_on = 1'b1;
        end else if (batt_short) begin
            batt_switch_on = 1'b0;
        end else if (!eff_path_en) begin
            batt_switch_on = 1'b1;
        end else if (normal_ac || normal_usb) begin
            batt_switch_on = supplement || charging;
        end else begin
            batt_switch_on = 1'b1;
        end
    end
    assign input_pullups_on = bus_below_short;
    assign batt_pullup_on   = batt_short && !thermal_shutdown;

    always_comb begin
        if (ac_switch_on) begin
            src = SRC_AC;
        end else if (usb_switch_on) begin
            src = SRC_USB;
        end else begin
            src = SRC_BATT;
        end
    end

    // sticky over-voltage flags, cleared by writing the status word; set wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ovp_ac_r  <= 1'b0;
            ovp_usb_r <= 1'b0;
        end else begin
            if (ac_overvolt) begin
                ovp_ac_r <= 1'b1;
            end else if (wr_en && paddr == STAT_OFF && pwdata[2]) begin
                ovp_ac_r <= 1'b0;
            end
            if (usb_overvolt) begin
                ovp_usb_r <= 1'b1;
            end else if (wr_en && paddr == STAT_OFF && pwdata[3]) begin
                ovp_usb_r <= 1'b0;
            end
        end
    end

    assign power_path_status_register = {supplement, pack_gone, batt_short,
                                         bus_below_short, ovp_usb_r, ovp_ac_r, src};

    // pack id source follows sleep control
    assign pack_id_src_on = !ctl_r[CTL_SLEEP];
    assign pack_id_current_select =
        charge_config_register[CFG_ID_LSB +: CFG_ID_W];

    // charge restart triggers: enable toggle or input re-insertion
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            run_en_d_r <= 1'b0;
            ext_d_r    <= 1'b0;
            restart_r  <= 1'b0;
        end else begin
            run_en_d_r <= eff_run_en && eff_path_en;
            ext_d_r    <= ext_present;
            if ((eff_run_en && eff_path_en && !run_en_d_r) || (ext_present && !ext_d_r)) begin
                restart_r <= 1'b1;
            end else if (chg_r == CHG_PRE || chg_r == CHG_CC) begin
                restart_r <= 1'b0;
            end
        end
    end

    // charge sequencer
    always_comb begin
        chg_nxt = chg_r;
        case (chg_r)
            CHG_IDLE: begin
                // an expired timer holds off a new start, else idle and cc would alternate
                if (ext_present && eff_run_en && eff_path_en && !eff_suspend
                    && batt_below_recharge && !ctl_r[CTL_TMR_EXP]) begin
                    chg_nxt = batt_below_3v ? CHG_PRE : CHG_CC;
                end
            end
            CHG_PRE: begin
                if (!batt_below_3v) begin
                    chg_nxt = CHG_CC;
                end
            end
            CHG_CC: begin
                if (batt_at_reg_volt) begin
                    chg_nxt = CHG_CV;
                end
            end
            CHG_CV: begin
                if (charge_below_term && term_enable) begin
                    chg_nxt = CHG_DONE;
                end
            end
            CHG_DONE: begin
                if (restart_r || batt_below_recharge) begin
                    chg_nxt = CHG_IDLE;
                end
            end
            default: chg_nxt = CHG_IDLE;
        endcase
        if (chg_r != CHG_IDLE && chg_r != CHG_DONE &&
            (!ext_present || !eff_run_en || !eff_path_en || eff_suspend ||
             ctl_r[CTL_TMR_EXP])) begin
            chg_nxt = CHG_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chg_r <= CHG_IDLE;
        end else begin
            chg_r <= chg_nxt;
        end
    end

    assign charging           = chg_r == CHG_PRE || chg_r == CHG_CC || chg_r == CHG_CV;
    assign charge_enabled     = charging;
    assign safety_timer_start = chg_r == CHG_IDLE && chg_nxt != CHG_IDLE;
    assign precharge_tenth    = chg_r == CHG_PRE;
    assign voltage_loop_on    = chg_r == CHG_CV;
    assign charge_reduce      = thermal_loop_hot || overload_active;
    assign term_enable        = !thermal_loop_hot && !overload_active && !supplement;
endmodule
`default_nettype wire

//--- tb/pp_supply_model.sv
// Purpose: far-side supplies and cell seen as comparator flags
// Assumes: supply presence and load set by the bench at clock edges
// Notes: pure levels, no analogue delay modelled
`timescale 1ns/1ps
`default_nettype none
module pp_supply_model (
    input  wire logic ac_on,
    input  wire logic usb_on,
    input  wire logic heavy_load,
    output logic      ac_above_batt,
    output logic      usb_above_batt,
    output logic      bus_below_batt
);
    // a plugged supply always sits above the cell voltage
    assign ac_above_batt  = ac_on;
    assign usb_above_batt = usb_on;
    // an overload drags the bus under the cell
    assign bus_below_batt = heavy_load;
endmodule
`default_nettype wire

//--- tb/pp_chk.sv
// Purpose: port-level checks of the power path selector
// Assumes: one clock domain, nrst async active low
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module pp_chk
    import pp_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     nrst,
    input wire logic     ac_above_batt,
    input wire logic     usb_above_batt,
    input wire logic     bus_below_short,
    input wire logic     batt_short,
    input wire logic     thermal_shutdown,
    input wire logic     pack_id_high,
    input wire logic     thermal_loop_hot,
    input wire logic     overload_active,
    input wire logic     ac_switch_on,
    input wire logic     usb_switch_on,
    input wire logic     batt_switch_on,
    input wire logic     input_pullups_on,
    input wire logic     batt_pullup_on,
    input wire logic     discharge_on,
    input wire usb_lim_e usb_limit,
    input wire logic     charge_enabled,
    input wire logic     charge_reduce,
    input wire logic     safety_timer_start,
    input wire logic     term_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_inputs_exclusive: assert property (!(ac_switch_on && usb_switch_on))
        else $error("both input switches on");
    a_ac_detected: assert property (ac_switch_on |-> ac_above_batt)
        else $error("adapter switch on without adapter");
    a_usb_second: assert property (usb_switch_on |-> usb_above_batt && !ac_above_batt)
        else $error("usb switch on out of priority");
    a_thermal_off: assert property (thermal_shutdown && !batt_short |->
        !ac_switch_on && !usb_switch_on && batt_switch_on)
        else $error("thermal shutdown switch state wrong");
    a_short_pullup: assert property (bus_below_short |->
        !ac_switch_on && !usb_switch_on && input_pullups_on)
        else $error("output short handling wrong");
    a_batt_short: assert property (batt_short && !thermal_shutdown |->
        !batt_switch_on && batt_pullup_on)
        else $error("battery short handling wrong");
    a_pack_removed: assert property (pack_id_high [*8] ##1 pack_id_high |-> ##[0:2] discharge_on)
        else $error("discharge not started");
    a_pack_glitch: assert property ($rose(discharge_on) |-> $past(pack_id_high, 4))
        else $error("discharge without steady pack flag");
    a_timer_pulse: assert property (safety_timer_start |=> !safety_timer_start)
        else $error("timer start longer than one cycle");
    a_thermal_reduce: assert property (thermal_loop_hot && charge_enabled |-> charge_reduce)
        else $error("thermal loop not reducing charge");
    a_term_blocked: assert property (thermal_loop_hot || overload_active |-> !term_enable)
        else $error("termination enabled during loop");
    a_limit_code: assert property (usb_limit != 2'h3)
        else $error("illegal usb limit code");
    c_ac: cover property (ac_switch_on);
    c_usb: cover property (usb_switch_on);
    c_disch: cover property ($rose(discharge_on));
    c_timer: cover property (safety_timer_start);
endmodule
`default_nettype wire

//--- tb/power_path_selector_tb.sv
// Purpose: directed apb and flag sequences for the power path selector
// Assumes: short boot hold of 10 cycles
// Notes: output checks taken at the falling edge, after combinational settling; apb read data and error checked at the rising edge
`timescale 1ns/1ps
`default_nettype none
module power_path_selector_tb;
    import pp_pkg::*;
    logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ac_on, usb_on, heavy, ac_above_batt, usb_above_batt, bus_below_batt;
    logic        ac_overvolt, usb_overvolt, bus_below_short, batt_short, thermal_shutdown;
    logic        pack_id_high, charge_at_zero, overload_active, thermal_loop_hot;
    logic        batt_below_recharge, batt_below_3v, batt_at_reg_volt, charge_below_term;
    logic        ac_switch_on, usb_switch_on, batt_switch_on, input_pullups_on;
    logic        batt_pullup_on, discharge_on, pack_id_src_on, charge_enabled;
    logic        charge_reduce, precharge_tenth, voltage_loop_on, safety_timer_start;
    logic        term_enable;
    logic [1:0]  pack_id_current_select;
    usb_lim_e    usb_limit;
    int          err_count, cmp_count, cyc, n;
    byte         seq [4] = '{3, 1, 2, 0};
    power_path_selector #(.BOOT_HOLD(10)) dut_u (.core_clk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ac_above_batt,
        .usb_above_batt, .ac_overvolt, .usb_overvolt, .bus_below_batt, .bus_below_short,
        .batt_short, .thermal_shutdown, .pack_id_high, .charge_at_zero, .overload_active,
        .thermal_loop_hot, .batt_below_recharge, .batt_below_3v, .batt_at_reg_volt,
        .charge_below_term, .ac_switch_on, .usb_switch_on, .batt_switch_on,
        .input_pullups_on, .batt_pullup_on, .discharge_on, .pack_id_src_on,
        .pack_id_current_select, .usb_limit, .charge_enabled, .charge_reduce,
        .precharge_tenth, .voltage_loop_on, .safety_timer_start, .term_enable);
    pp_supply_model model_u (.ac_on, .usb_on, .heavy_load(heavy), .ac_above_batt,
        .usb_above_batt, .bus_below_batt);
    always #50 core_clk = ~core_clk;
    // hang guard, far above the fewer than two hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            stop_test();
        end
    end
    function automatic logic [2:0] sw();
        return {ac_switch_on, usb_switch_on, batt_switch_on};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        {nrst, psel, penable, pwrite, paddr, pwdata, ac_on, usb_on, heavy, ac_overvolt,
         usb_overvolt, bus_below_short, batt_short, thermal_shutdown, pack_id_high,
         charge_at_zero, overload_active, thermal_loop_hot, batt_below_recharge,
         batt_below_3v, batt_at_reg_volt, charge_below_term} = '0;
        repeat (12) @(posedge core_clk);
        nrst  <= 1'b1;
        ac_on <= 1'b1;
        // host turns path off during boot hold, which must not bite yet
        apb(1'b1, CFG_OFF, 32'h08);
        tick(1);
        chk(sw(), 3'b100);
        chk(usb_limit, LIM_100MA);
        tick(12);
        chk(sw(), 3'b001);
        chk(usb_limit, LIM_2A75);
        rd_chk(CFG_OFF, 32'h08);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, CFG_OFF, 32'(1 + 4 * i));
            tick(1);
            chk(usb_limit, (i == 0) ? 0 : ((i == 1) ? 1 : 2));
        end
        // supplies come and go, charging off so the cell stays idle
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            ac_on  <= seq[i][1];
            usb_on <= seq[i][0];
            tick(1);
            chk(sw(), {seq[i][1], seq[i] == 1, seq[i] == 0});
            rd_chk(STAT_OFF, seq[i][1] ? 1 : (seq[i][0] ? 2 : 0));
        end
        @(posedge core_clk);
        ac_on <= 1'b1;
        heavy <= 1'b1;
        tick(1);
        chk(sw(), 3'b100);
        @(posedge core_clk);
        charge_at_zero <= 1'b1;
        tick(1);
        chk(sw(), 3'b101);
        rd_chk(STAT_OFF, 32'h81);
        @(posedge core_clk);
        {heavy, charge_at_zero, ac_overvolt, usb_overvolt} <= 4'b0011;
        tick(1);
        chk(sw(), 3'b100);
        @(posedge core_clk);
        {ac_overvolt, usb_overvolt} <= 2'b00;
        rd_chk(STAT_OFF, 32'h0d);
        apb(1'b1, STAT_OFF, 32'h0c);
        rd_chk(STAT_OFF, 32'h01);
        @(posedge core_clk);
        thermal_shutdown <= 1'b1;
        tick(1);
        chk(sw(), 3'b001);
        @(posedge core_clk);
        {thermal_shutdown, bus_below_short} <= 2'b01;
        tick(1);
        chk({sw() & 3'b110, input_pullups_on}, 4'h1);
        @(posedge core_clk);
        {bus_below_short, ac_on, batt_short} <= 3'b001;
        tick(1);
        chk({batt_switch_on, batt_pullup_on}, 2'b01);
        @(posedge core_clk);
        {batt_short, ac_on} <= 2'b01;
        tick(1);
        chk(sw(), 3'b100);
        // forced battery mode with the pack pulled while both supplies sit present
        apb(1'b1, CFG_OFF, 32'h40);
        @(posedge core_clk);
        {usb_on, pack_id_high} <= 2'b11;
        tick(11);
        chk({discharge_on, sw()}, 4'h9);
        chk({pack_id_src_on, pack_id_current_select}, 3'b110);
        @(posedge core_clk);
        {pack_id_high, usb_on} <= 2'b00;
        apb(1'b1, CTL_OFF, 32'h1);
        tick(1);
        chk(pack_id_src_on, 1'b0);
        apb(1'b1, CTL_OFF, 32'h0);
        apb(1'b1, CFG_OFF, 32'h03);
        tick(8);
        @(posedge core_clk);
        {batt_below_recharge, batt_below_3v} <= 2'b11;
        n = 0;
        repeat (6) begin
            tick(1);
            if (safety_timer_start === 1'b1) n++;
        end
        chk(n, 1);
        chk({charge_enabled, precharge_tenth}, 2'b11);
        @(posedge core_clk);
        batt_below_3v <= 1'b0;
        tick(2);
        chk({charge_enabled, precharge_tenth, voltage_loop_on}, 3'b100);
        @(posedge core_clk);
        batt_at_reg_volt <= 1'b1;
        tick(2);
        chk(voltage_loop_on, 1'b1);
        @(posedge core_clk);
        thermal_loop_hot <= 1'b1;
        tick(1);
        chk({charge_reduce, term_enable}, 2'b10);
        // expired safety timer aborts the charge and holds off a restart
        apb(1'b1, CTL_OFF, 32'h2);
        tick(3);
        chk({charge_enabled, safety_timer_start}, 2'b00);
        // unmapped word reads as zero with an error response
        rd_chk(8'h0c, 32'h0);
        chk(last_err, 1'b1);
        stop_test();
    end
endmodule
bind power_path_selector pp_chk chk_u (.core_clk, .nrst, .ac_above_batt, .usb_above_batt,
    .bus_below_short, .batt_short, .thermal_shutdown, .pack_id_high, .thermal_loop_hot,
    .overload_active, .ac_switch_on, .usb_switch_on, .batt_switch_on, .input_pullups_on,
    .batt_pullup_on, .discharge_on, .usb_limit, .charge_enabled, .charge_reduce,
    .safety_timer_start, .term_enable);
`default_nettype wire
